// File: design/pla_pkg.sv
package pla_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int          NL      = 20;      // PCS lanes
  localparam int          NSEG    = 3;       // Packet segments per cycle
  localparam int unsigned MF_DEF  = 16384;   // Blocks per marker period
  localparam int unsigned SRCH_MF = 2;       // Marker periods before giving up

  // ------------------------------------------------------------
  // Lock, marker and alignment limits
  // ------------------------------------------------------------
  localparam logic [6:0] LOCK_GOOD   = 7'h40; // Good headers to lock
  localparam logic [4:0] BAD_LIM     = 5'h10; // Bad headers per window to unlock
  localparam logic [2:0] REP_LIM     = 3'h4;  // Bad markers in a row
  localparam logic [3:0] SKEW_MAX    = 4'hf;  // Cycles after the first marker the rest must land in
  localparam logic [2:0] ALIGN_TRIES = 3'h4;  // Failed rounds before align fail

  // ------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------
  localparam int         AW        = 8;
  localparam int         A_STAT    = 7;       // Status space select bit
  localparam int         A_TX      = 6;       // Transmit marker select bit
  localparam logic [7:0] STAT_ALGN = 8'h80;
  localparam logic [7:0] STAT_SYNC = 8'h81;

  // Reset marker values, lane 0 first
  localparam logic [63:0] MK_DEF [NL] = '{
    64'hc1_68_21_00_3e_97_de_00, 64'h9d_71_8e_00_62_8e_71_00,
    64'h59_4b_e8_00_a6_b4_17_00, 64'h4d_95_7b_00_b2_6a_84_00,
    64'hf5_07_09_00_0a_f8_f6_00, 64'hdd_14_c2_00_22_eb_3d_00,
    64'h9a_4a_26_00_65_b5_d9_00, 64'h7b_45_66_00_84_ba_99_00,
    64'ha0_24_76_00_5f_db_89_00, 64'h68_c9_fb_00_97_36_04_00,
    64'hfd_6c_99_00_02_93_66_00, 64'hb9_91_55_00_46_6e_aa_00,
    64'h5c_b9_b2_00_a3_46_4d_00, 64'h1a_f8_bd_00_e5_07_42_00,
    64'h83_c7_ca_00_7c_38_35_00, 64'h35_36_cd_00_ca_c9_32_00,
    64'hc4_31_4c_00_3b_ce_b3_00, 64'had_d6_b7_00_52_29_48_00,
    64'h5f_66_2a_00_a0_99_d5_00, 64'hc0_f0_e5_00_3f_0f_1a_00};

  // ------------------------------------------------------------
  // State carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        locked;
    logic        found;
    logic        syncd;
    logic [4:0]  lid;
    logic [6:0]  good;
    logic [4:0]  bad;
    logic [5:0]  win;
    logic [16:0] mf_cnt;
    logic [2:0]  rep;
    logic        sync_fail;
    logic        rate_err;
    logic        rep_err;
    logic        mk_inv;
    logic        mk_hit;
    logic        ferr_v;
    logic [1:0]  ferr;
  } pla_lane_s;

  typedef struct packed {
    pla_lane_s [NL-1:0]        ln;
    logic [NL-1:0][63:0]       rxm;
    logic [NL-1:0][63:0]       txm;
    logic [NL-1:0][3:0]        xcvr;
    logic [NL-1:0]             dmx;
    logic                      act;
    logic [NL-1:0]             mask;
    logic [3:0]                skw;
    logic [2:0]                tries;
    logic                      aligned;
    logic                      align_fail;
    logic                      misal;
    logic                      link_ok;
    logic                      fault;
    logic [NSEG-1:0]           crc;
    logic [NSEG-1:0]           eop;
    logic [NSEG-1:0]           perr;
    logic [2:0]                badc;
    logic [31:0]               rdata;
  } pla_state_s;

endpackage : pla_pkg

// File: design/pla_lane_align_status.sv
`timescale 1ns/1ps

module pla_lane_align_status
  import pla_pkg::*;
#(
  parameter int unsigned MF_LEN = MF_DEF
) (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic [AW-1:0]         reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  caui4_mode,
  input  wire logic [NL-1:0]         lane_blk_vld,
  input  wire logic [NL-1:0][1:0]    lane_hdr,
  input  wire logic [NL-1:0][63:0]   lane_data,
  input  wire logic                  rx_high_error_rate,
  input  wire logic                  int_local_fault,
  input  wire logic                  rcv_local_fault,
  input  wire logic [NSEG-1:0]       seg_eop,
  input  wire logic [NSEG-1:0]       seg_crc_bad,
  input  wire logic                  rx_skip_crc_check,
  input  wire logic [2:0]            dec_err,
  output logic [NL-1:0][63:0]        rx_lane_marker_value,
  output logic [NL-1:0][63:0]        tx_lane_marker_value,
  output logic [NL-1:0]              lane_word_synced,
  output logic [NL-1:0]              lane_sync_fail,
  output logic [NL-1:0]              marker_rate_err,
  output logic [NL-1:0]              marker_repeat_err,
  output logic [NL-1:0]              marker_invalid_pulse,
  output logic [NL-1:0]              header_lock,
  output logic [NL-1:0]              lane_demux_ok,
  output logic [NL-1:0][4:0]         lane_map_index,
  output logic [NL-1:0][3:0]         lane_xcvr,
  output logic [NL-1:0][1:0]         hdr_err_count,
  output logic [NL-1:0]              hdr_err_valid,
  output logic                       all_lanes_aligned,
  output logic                       alignment_fail,
  output logic                       lanes_misaligned_pulse,
  output logic                       link_rx_ok,
  output logic                       rx_fault_any,
  output logic [NSEG-1:0]            crc_mismatch,
  output logic [NSEG-1:0]            rx_end_of_packet_flag,
  output logic [NSEG-1:0]            rx_packet_error_flag,
  output logic [2:0]                 bad_code_count
);

  localparam logic [16:0] MF_LAST = 17'(MF_LEN - 1);
  localparam logic [16:0] SRCH    = 17'(SRCH_MF * MF_LEN - 1);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Marker lookup: {hit, lane index}
  function automatic logic [5:0] mk_lookup(input logic [63:0] d,
                                           input logic [NL-1:0][63:0] m);
    logic [5:0] r;
    r = '0;
    for (int k = 0; k < NL; k++) begin
      if (d == m[k]) begin
        r = {1'b1, 5'(k)};
      end
    end
    return r;
  endfunction : mk_lookup

  // Physical lane to transceiver index
  function automatic logic [3:0] xcvr_of(input int p, input logic four);
    return four ? 4'(p / 5) : 4'(p / 2);
  endfunction : xcvr_of

  // Raise the lane error chosen by which (none for 2'h3) and drop the others
  function automatic pla_lane_s set_err(input pla_lane_s l, input logic [1:0] which);
    pla_lane_s r;
    r = l;
    r.sync_fail = (which == 2'h0);
    r.rate_err  = (which == 2'h1);
    r.rep_err   = (which == 2'h2);
    r.syncd     = 1'b0;
    r.found     = 1'b0;
    r.mf_cnt    = '0;
    return r;
  endfunction : set_err

  pla_state_s st_reg;
  pla_state_s st_next;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------

  // All lane, alignment, packet and register behaviour
  always_comb begin
    pla_lane_s  l;
    logic [5:0] lk;
    logic       hok;
    logic [4:0] wl;
    logic [NL-1:0] hits;
    logic [NL-1:0] dup;
    logic       good_rnd;
    st_next  = st_reg;
    l        = '0;
    lk       = '0;
    hok      = 1'b0;
    wl       = reg_addr[5:1];
    hits     = '0;
    dup      = '0;
    good_rnd = 1'b0;

    // Marker settings writes
    if (reg_wr && !reg_addr[A_STAT] && (wl < 5'(NL))) begin
      if (reg_addr[A_TX]) begin
        if (reg_addr[0]) st_next.txm[wl][63:32] = reg_wdata;
        else st_next.txm[wl][31:0] = reg_wdata;
      end else begin
        if (reg_addr[0]) st_next.rxm[wl][63:32] = reg_wdata;
        else st_next.rxm[wl][31:0] = reg_wdata;
      end
    end

    // Per-lane lock, marker tracking and errors
    for (int i = 0; i < NL; i++) begin
      l        = st_reg.ln[i];
      l.mk_inv = 1'b0;
      l.mk_hit = 1'b0;
      l.ferr_v = 1'b0;
      if (lane_blk_vld[i]) begin
        hok      = ^lane_hdr[i];
        lk       = mk_lookup(lane_data[i], st_reg.rxm);
        l.ferr_v = 1'b1;
        l.ferr   = hok ? 2'h0 : 2'h1;
        if (!l.found) begin
          if (l.mf_cnt == SRCH) l = set_err(l, 2'h0);
          else l.mf_cnt = l.mf_cnt + 17'h1;
        end
        if (!l.locked) begin
          l.good = hok ? l.good + 7'h1 : 7'h0;
          if (l.good == LOCK_GOOD) begin
            l.locked = 1'b1;
            l.good   = '0;
            l.win    = '0;
            l.bad    = '0;
          end
        end else begin
          l.win = l.win + 6'h1;
          if (!hok) l.bad = l.bad + 5'h1;
          if (l.bad == BAD_LIM) begin
            l        = set_err(l, 2'h0);
            l.locked = 1'b0;
          end else begin
            if (l.win == '0) l.bad = '0;
            if (!l.found) begin
              if (hok && lk[5]) begin
                l           = set_err(l, 2'h3);
                l.found     = 1'b1;
                l.syncd     = 1'b1;
                l.lid       = lk[4:0];
                l.rep       = '0;
                l.mk_hit    = 1'b1;
              end
            end else if (l.mf_cnt == MF_LAST) begin
              l.mf_cnt = '0;
              if (hok && lk[5] && (lk[4:0] == l.lid)) begin
                l.rep    = '0;
                l.mk_hit = 1'b1;
              end else begin
                l.mk_inv = 1'b1;
                l.rep    = l.rep + 3'h1;
                if (l.rep == REP_LIM) l = set_err(l, 2'h2);
              end
            end else begin
              l.mf_cnt = l.mf_cnt + 17'h1;
              if (hok && lk[5]) l = set_err(l, 2'h1);
            end
          end
        end
      end
      st_next.ln[i] = l;
      hits[i]       = l.mk_hit;
    end

    // Duplicate lane identities among synced lanes
    for (int i = 0; i < NL; i++) begin
      for (int j = 0; j < NL; j++) begin
        if (i != j && st_next.ln[i].syncd && st_next.ln[j].syncd &&
            st_next.ln[i].lid == st_next.ln[j].lid) begin
          dup[i] = 1'b1;
        end
      end
      st_next.dmx[i]  = st_next.ln[i].syncd && !dup[i];
      st_next.xcvr[i] = xcvr_of(i, caui4_mode);
    end

    // Deskew rounds: all markers must land within the skew window
    st_next.misal = 1'b0;
    if (!st_reg.act) begin
      if (|hits) begin
        st_next.act  = 1'b1;
        st_next.mask = hits;
        st_next.skw  = '0;
      end
    end else begin
      st_next.mask = st_reg.mask | hits;
      st_next.skw  = st_reg.skw + 4'h1;
    end
    if (st_next.act && (&st_next.mask)) begin
      st_next.act = 1'b0;
      good_rnd    = &st_next.dmx;
    end else if (st_next.act && st_next.skw == SKEW_MAX) begin
      st_next.act   = 1'b0;
      st_next.misal = 1'b1;
    end
    if (good_rnd) begin
      st_next.aligned = 1'b1;
      st_next.tries   = '0;
    end else if (st_next.misal || (st_reg.act && !st_next.act)) begin
      st_next.aligned = 1'b0;
      if (st_reg.tries != ALIGN_TRIES) st_next.tries = st_reg.tries + 3'h1;
    end
    if (!(&st_next.dmx)) st_next.aligned = 1'b0;
    if (good_rnd) st_next.align_fail = 1'b0;
    if ((st_reg.aligned && !st_next.aligned) ||
        (st_next.tries == ALIGN_TRIES)) begin
      st_next.align_fail = 1'b1;
    end
    st_next.link_ok = st_next.aligned && !rx_high_error_rate;
    st_next.fault   = int_local_fault | rcv_local_fault;

    // Packet end flags and CRC results
    st_next.eop  = seg_eop;
    st_next.crc  = seg_eop & seg_crc_bad;
    st_next.perr = seg_eop & seg_crc_bad & {NSEG{!rx_skip_crc_check}};
    st_next.badc = 3'(dec_err[0]) + 3'(dec_err[1]) + 3'(dec_err[2]);

    // Read data, valid only in the cycle after the strobe
    st_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == STAT_ALGN) begin
        st_next.rdata = {26'h0, st_reg.misal, st_reg.fault, st_reg.link_ok,
                         st_reg.act, st_reg.align_fail, st_reg.aligned};
      end else if (reg_addr == STAT_SYNC) begin
        st_next.rdata = {12'h0, lane_word_synced};
      end else if (!reg_addr[A_STAT] && (wl < 5'(NL))) begin
        if (reg_addr[A_TX]) begin
          st_next.rdata = reg_addr[0] ? st_reg.txm[wl][63:32] : st_reg.txm[wl][31:0];
        end else begin
          st_next.rdata = reg_addr[0] ? st_reg.rxm[wl][63:32] : st_reg.rxm[wl][31:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------

  // Single clock edge updates everything
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      for (int i = 0; i < NL; i++) begin
        st_reg.rxm[i]  <= MK_DEF[i];
        st_reg.txm[i]  <= MK_DEF[i];
        st_reg.xcvr[i] <= xcvr_of(i, 1'b0);
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // Straight from the state register
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      lane_word_synced[i]     = st_reg.ln[i].syncd;
      lane_sync_fail[i]       = st_reg.ln[i].sync_fail;
      marker_rate_err[i]      = st_reg.ln[i].rate_err;
      marker_repeat_err[i]    = st_reg.ln[i].rep_err;
      marker_invalid_pulse[i] = st_reg.ln[i].mk_inv;
      header_lock[i]          = st_reg.ln[i].locked;
      lane_map_index[i]       = st_reg.ln[i].lid;
      hdr_err_count[i]        = st_reg.ln[i].ferr;
      hdr_err_valid[i]        = st_reg.ln[i].ferr_v;
    end
  end

  assign reg_rdata              = st_reg.rdata;
  assign rx_lane_marker_value   = st_reg.rxm;
  assign tx_lane_marker_value   = st_reg.txm;
  assign lane_demux_ok          = st_reg.dmx;
  assign lane_xcvr              = st_reg.xcvr;
  assign all_lanes_aligned      = st_reg.aligned;
  assign alignment_fail         = st_reg.align_fail;
  assign lanes_misaligned_pulse = st_reg.misal;
  assign link_rx_ok             = st_reg.link_ok;
  assign rx_fault_any           = st_reg.fault;
  assign crc_mismatch           = st_reg.crc;
  assign rx_end_of_packet_flag  = st_reg.eop;
  assign rx_packet_error_flag   = st_reg.perr;
  assign bad_code_count         = st_reg.badc;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_sync_excl: assert property ((lane_word_synced & lane_sync_fail) == '0)
    else $error("synced and sync fail together");
  a_synced_lock: assert property ((lane_word_synced & ~header_lock) == '0)
    else $error("synced lane without header lock");
  a_rate_excl: assert property ((marker_rate_err & lane_word_synced) == '0)
    else $error("rate error on synced lane");
  a_rep_cause: assert property (
    ((marker_repeat_err & ~$past(marker_repeat_err)) & ~marker_invalid_pulse) == '0)
    else $error("repeat error without bad marker");
  a_inv_one: assert property (|marker_invalid_pulse |=> ~|marker_invalid_pulse)
    else $error("bad marker pulse too long");
  a_aligned_all: assert property (all_lanes_aligned |-> &lane_demux_ok)
    else $error("aligned with lane missing");
  a_align_drop: assert property ($fell(all_lanes_aligned) |-> alignment_fail)
    else $error("alignment loss not flagged");
  a_misal_pulse: assert property (
    lanes_misaligned_pulse |-> ##1 !lanes_misaligned_pulse[*2])
    else $error("misaligned pulse too long");
  a_link_ok: assert property (
    link_rx_ok == (all_lanes_aligned && !$past(rx_high_error_rate)))
    else $error("link ok wrong");
  a_fault_or: assert property (
    rx_fault_any == $past(int_local_fault || rcv_local_fault))
    else $error("fault output wrong");
  a_crc_pulse: assert property (crc_mismatch == $past(seg_eop & seg_crc_bad))
    else $error("crc pulse wrong");
  a_err_flag: assert property (
    rx_packet_error_flag == ($past(seg_crc_bad & {NSEG{!rx_skip_crc_check}})
                             & rx_end_of_packet_flag))
    else $error("packet error flag wrong");
  a_bad_code: assert property (
    bad_code_count == 3'($countones($past(dec_err))))
    else $error("bad code count wrong");

  c_aligned: cover property ($rose(all_lanes_aligned));
  c_misal: cover property (lanes_misaligned_pulse);
  c_repeat: cover property ($rose(|marker_repeat_err));
  c_crc_err: cover property (|rx_packet_error_flag);

endmodule : pla_lane_align_status

// File: sim/pla_tx_model.sv
`timescale 1ns/1ps
// Remote transmitter: twenty lanes, one block per cycle while enabled
module pla_tx_model
  import pla_pkg::*;
#(
  parameter int unsigned MF_LEN = 16
) (
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire logic           en,
  input  wire logic           slip,
  input  wire logic           mk_bad,
  input  wire logic           hdr_bad,
  output logic [NL-1:0]       lane_blk_vld,
  output logic [NL-1:0][1:0]  lane_hdr,
  output logic [NL-1:0][63:0] lane_data
);
  logic [16:0] cnt;
  logic [16:0] off;
  // Blocks; lane 0 slot may be shifted, its markers or headers spoiled
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      off <= '0;
      lane_blk_vld <= '0;
      lane_hdr <= '0;
      lane_data <= '0;
    end else begin
      cnt <= !en ? cnt : (cnt == MF_LEN - 1) ? '0 : cnt + 17'h1;
      off <= off + 17'(slip);
      for (int i = 0; i < NL; i++) begin
        logic m;
        m = (((i == 0) ? cnt + off : cnt) % MF_LEN) == MF_LEN - 1;
        lane_blk_vld[i] <= en;
        // Idle lines show a changing pattern, never the last value
        lane_hdr[i] <= !en ? ~lane_hdr[i] : (hdr_bad && i == 0) ? 2'h0 : m ? 2'h2 : 2'h1;
        lane_data[i] <= !en ? ~lane_data[i] : !m ? {47'h0, cnt} | 64'hff :
                        MK_DEF[i] ^ {55'h0, mk_bad && i == 0, 8'h0};
      end
    end
  end
endmodule : pla_tx_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pla_pkg::*;
  localparam int unsigned MFL = 32; // Longer than the skew window, so a slipped lane times out
  logic mclk, rstn, reg_wr, reg_rd, caui4_mode, rx_high_error_rate, int_local_fault;
  logic rcv_local_fault, rx_skip_crc_check, en, slip, mk_bad, hdr_bad;
  logic [AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [NL-1:0][63:0] rx_lane_marker_value, tx_lane_marker_value, lane_data;
  logic [NL-1:0] lane_word_synced, lane_sync_fail, marker_rate_err, marker_repeat_err;
  logic [NL-1:0] marker_invalid_pulse, header_lock, lane_demux_ok, hdr_err_valid, lane_blk_vld;
  logic [NL-1:0][4:0] lane_map_index;
  logic [NL-1:0][3:0] lane_xcvr;
  logic [NL-1:0][1:0] hdr_err_count, lane_hdr;
  logic all_lanes_aligned, alignment_fail, lanes_misaligned_pulse, link_rx_ok, rx_fault_any;
  logic [NSEG-1:0] seg_eop, seg_crc_bad, crc_mismatch, rx_end_of_packet_flag;
  logic [NSEG-1:0] rx_packet_error_flag;
  logic [2:0] dec_err, bad_code_count;
  int num_errors = 0, compares = 0, cycles = 0, inv_cnt = 0, mis_cnt = 0, af_cnt = 0;
  int k, n0;

  pla_lane_align_status #(.MF_LEN(MFL)) u_pla_lane_align_status (
    .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .caui4_mode,
    .lane_blk_vld, .lane_hdr, .lane_data, .rx_high_error_rate, .int_local_fault,
    .rcv_local_fault, .seg_eop, .seg_crc_bad, .rx_skip_crc_check, .dec_err,
    .rx_lane_marker_value, .tx_lane_marker_value, .lane_word_synced, .lane_sync_fail,
    .marker_rate_err, .marker_repeat_err, .marker_invalid_pulse, .header_lock,
    .lane_demux_ok, .lane_map_index, .lane_xcvr, .hdr_err_count, .hdr_err_valid,
    .all_lanes_aligned, .alignment_fail, .lanes_misaligned_pulse, .link_rx_ok,
    .rx_fault_any, .crc_mismatch, .rx_end_of_packet_flag, .rx_packet_error_flag,
    .bad_code_count);
  pla_tx_model #(.MF_LEN(MFL)) u_pla_tx_model (
    .mclk, .rstn, .en, .slip, .mk_bad, .hdr_bad, .lane_blk_vld, .lane_hdr, .lane_data);

  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard and event counters
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    inv_cnt <= inv_cnt + int'(marker_invalid_pulse[0]);
    mis_cnt <= mis_cnt + int'(lanes_misaligned_pulse);
    af_cnt <= af_cnt + int'(alignment_fail);
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    {rstn, reg_wr, reg_rd, caui4_mode, rx_high_error_rate, int_local_fault} = '0;
    {rcv_local_fault, rx_skip_crc_check, en, slip, mk_bad, hdr_bad} = '0;
    {reg_addr, reg_wdata, seg_eop, seg_crc_bad, dec_err} = '0;
    tick(1);
    for (k = 0; k < NL; k++) begin
      chk(rx_lane_marker_value[k], MK_DEF[k]);
      chk(tx_lane_marker_value[k], MK_DEF[k]);
    end
    @(posedge mclk);
    rstn <= 1'b1;
    for (n0 = 1; n0 >= 0; n0--) begin
      @(posedge mclk);
      caui4_mode <= n0[0];
      tick(2);
      for (k = 0; k < NL; k++) chk(lane_xcvr[k], n0 ? k / 5 : k / 2);
    end
    rd(8'h01, v);
    chk(v, 32'hc1682100);
    rd(8'h67, v);
    chk(v, 32'hc0f0e500);
    wr(8'h4a, 32'h1234abcd);
    tick(1);
    chk(tx_lane_marker_value[5], {MK_DEF[5][63:32], 32'h1234abcd});
    wr(8'h28, 32'hffffffff);
    rd(8'h28, v);
    chk(v, 32'h0);
    // Packet ends, decoder errors and faults, all eight codes
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      {seg_eop, seg_crc_bad, rx_skip_crc_check} <= {3'h3, 3'h6, k[0]};
      {dec_err, int_local_fault, rcv_local_fault} <= {3'(k), k[1], k[2]};
      @(posedge mclk);
      {seg_eop, seg_crc_bad} <= '0;
      #1;
      chk(crc_mismatch, 3'h2);
      chk(rx_end_of_packet_flag, 3'h3);
      chk(rx_packet_error_flag, k[0] ? 3'h0 : 3'h2);
      chk(bad_code_count, $countones(3'(k)));
      chk(rx_fault_any, k[1] | k[2]);
    end
    // Bring all lanes up
    en <= 1'b1;
    for (k = 0; k < 200 && header_lock !== '1; k++) tick(1);
    chk(header_lock, {NL{1'b1}});
    for (k = 0; k < 400 && all_lanes_aligned !== 1'b1; k++) tick(1);
    chk(all_lanes_aligned, 1'b1);
    chk(lane_word_synced, {NL{1'b1}});
    chk(lane_demux_ok, {NL{1'b1}});
    for (k = 0; k < NL; k++) chk(lane_map_index[k], k);
    chk(link_rx_ok, 1'b1);
    rd(8'h81, v);
    chk(v, 32'h000fffff);
    rd(8'h80, v);
    chk(v & 32'h9, 32'h9);
    @(posedge mclk);
    rx_high_error_rate <= 1'b1;
    tick(2);
    chk(link_rx_ok, 1'b0);
    @(posedge mclk);
    rx_high_error_rate <= 1'b0;
    // Lane 0 markers one block early
    n0 = mis_cnt;
    @(posedge mclk);
    slip <= 1'b1;
    @(posedge mclk);
    slip <= 1'b0;
    for (k = 0; k < 100 && marker_rate_err[0] !== 1'b1; k++) tick(1);
    chk(marker_rate_err[0], 1'b1);
    for (k = 0; k < 300 && lane_word_synced[0] !== 1'b1; k++) tick(1);
    chk(marker_rate_err[0], 1'b0);
    chk(mis_cnt > n0, 1'b1);
    chk(af_cnt > 0, 1'b1);
    // Spoiled markers on lane 0
    n0 = inv_cnt;
    mk_bad <= 1'b1;
    for (k = 0; k < 200 && marker_repeat_err[0] !== 1'b1; k++) tick(1);
    chk(marker_repeat_err[0], 1'b1);
    chk(lane_word_synced[0], 1'b0);
    tick(2);
    chk(inv_cnt - n0, 4);
    for (k = 0; k < 200 && lane_sync_fail[0] !== 1'b1; k++) tick(1);
    chk(lane_sync_fail[0], 1'b1);
    chk(marker_repeat_err[0], 1'b0);
    // Illegal headers on lane 0
    hdr_bad <= 1'b1;
    tick(3);
    chk(hdr_err_valid[0], 1'b1);
    chk(hdr_err_count[0], 2'h1);
    for (k = 0; k < 100 && header_lock[0] !== 1'b0; k++) tick(1);
    chk(header_lock[0], 1'b0);
    chk(all_lanes_aligned, 1'b0);
    wr(8'h07, 32'h0badf00d);
    tick(1);
    chk(rx_lane_marker_value[3], {32'h0badf00d, MK_DEF[3][31:0]});
    close_out();
  end
endmodule : testbench
